// *** verif/hcnvm_checker.sv ***
// Port-level assertions for the encoder parameter store
`timescale 1ns/1ps
`default_nettype none
module hcnvm_checker
  import hcnvm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic prog_mode,
  input wire hcnvm_pkg::hcnvm_write_type prog_write,
  input wire logic tx_start,
  input wire logic [3:0] button_bits,
  input wire logic button_active,
  input wire logic repeat_word,
  input wire logic code_word_done,
  input wire logic below_trip_low,
  input wire logic below_trip_high,
  input wire logic [63:0] cipher_key,
  input wire hcnvm_pkg::hcnvm_plain_type plain_data,
  input wire hcnvm_pkg::hcnvm_fixed_type fixed_data,
  input wire logic frame_ready,
  input wire logic busy,
  input wire logic pulse_tick,
  input wire logic word_send,
  input wire logic timed_out,
  input wire logic low_battery
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // ==================================================
  // Programming path
  key_low_load_a: assert property (
    prog_mode && prog_write.we && prog_write.addr == IDX_KEY0
    |=> cipher_key[15:0] == $past(prog_write.data)) else $error("key word 0 not loaded");
  key_high_load_a: assert property (
    prog_mode && prog_write.we && prog_write.addr == IDX_KEY3
    |=> cipher_key[63:48] == $past(prog_write.data)) else $error("key word 3 not loaded");
  // ==================================================
  // Frame handshake
  ready_after_load_a: assert property (
    $rose(busy) |=> frame_ready) else $error("frame_ready late");
  store_then_idle_a: assert property (
    frame_ready |-> busy ##1 !busy) else $error("store cycle wrong");
  frame_data_hold_a: assert property (
    !frame_ready |-> $stable(plain_data) && $stable(fixed_data)) else $error("data moved");
  buttons_paired_a: assert property (
    frame_ready |-> fixed_data.button == plain_data.button) else $error("buttons differ");
  no_start_prog_a: assert property (
    !busy && prog_mode |=> !busy) else $error("frame started in programming");
  // ==================================================
  // Shutoff and pacing
  release_clears_a: assert property (
    !button_active |=> !timed_out) else $error("timeout held after release");
  no_start_timeout_a: assert property (
    timed_out && !busy |=> !busy) else $error("frame started after timeout");
  timeout_mutes_a: assert property (
    timed_out |-> !word_send) else $error("carrier on after timeout");
  tick_spacing_a: assert property (
    pulse_tick |=> !pulse_tick) else $error("pulse ticks adjacent");
endmodule : hcnvm_checker
bind hcnvm_store hcnvm_checker hcnvm_checker_i (.*);
`default_nettype wire

// *** verif/hcnvm_programmer.sv ***
// Production programmer model writing a parameter image, with reserved words 5 and 10 written as WORD_RESET instead
`timescale 1ns/1ps
`default_nettype none
module hcnvm_programmer
  import hcnvm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic start,
  input wire logic [191:0] image,
  output logic prog_mode,
  output hcnvm_pkg::hcnvm_write_type prog_write,
  output logic done
);
  int idx;
  initial
  begin
    prog_mode = 1'b0;
    prog_write = '0;
    done = 1'b0;
    idx = 0;
  end
  // Falling edge drive keeps each write settled at the sampling edge
  always @(negedge clk_sys)
  begin
    if (prog_mode && idx < WORD_COUNT)
    begin
      done <= 1'b0;
      prog_write.we <= 1'b1;
      prog_write.addr <= ADDR_W'(idx);
      prog_write.data <= (idx == 5 || idx == 10) ? WORD_RESET : image[idx*16 +: 16];
      idx <= idx + 1;
    end
    else
    begin
      // Idle data wanders instead of keeping the last word
      prog_write.we <= 1'b0;
      prog_write.data <= ~prog_write.data;
      done <= prog_mode;
      if (prog_mode)
      begin
        prog_mode <= 1'b0;
      end
      else if (start)
      begin
        prog_mode <= 1'b1;
        idx <= 0;
      end
    end
  end
endmodule : hcnvm_programmer
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the encoder parameter store
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hcnvm_pkg::*;
  localparam logic [63:0] KEY = 64'h0123_4567_89ab_cdef;
  localparam logic [31:0] SER = 32'h8abc_def1;
  localparam int SH = 20;
  localparam int GAP [4] = '{8, 4, 2, 2};
  logic clk_sys, reset_n, prog_mode, tx_start, button_active, repeat_word, start, done;
  logic code_word_done, below_trip_low, below_trip_high, frame_ready, busy;
  logic pulse_tick, word_send, timed_out, low_battery;
  logic [3:0] button_bits;
  logic [63:0] cipher_key;
  logic [191:0] image;
  hcnvm_write_type prog_write;
  hcnvm_plain_type plain_data;
  hcnvm_fixed_type fixed_data;
  int failures = 0;
  int checked = 0;
  int n;
  hcnvm_store #(.ELEM_400(16'h0008), .ELEM_200(16'h0004), .ELEM_100(16'h0002),
    .SHUTOFF(32'h0000_0014)) hcnvm_store_i (.*);
  hcnvm_programmer hcnvm_programmer_i (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  function automatic logic [191:0] img(input logic [15:0] hop, input logic [15:0] opt,
    input logic [31:0] ser);
    return {opt, 16'h5a5a, 32'h0000_0000, ser, 16'hffff, hop, KEY};
  endfunction : img
  task automatic load_image(input logic [191:0] im);
    image <= im;
    start <= 1'b1;
    @(negedge clk_sys);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40)
    begin
      @(negedge clk_sys);
      n++;
    end
  endtask : load_image
  task automatic tx(input logic [3:0] b);
    button_bits <= b;
    tx_start <= 1'b1;
    @(negedge clk_sys);
    tx_start <= 1'b0;
    n = 0;
    while (frame_ready !== 1'b1 && n < 8)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("frame_ready", 64'h1, {63'h0, frame_ready});
  endtask : tx
  task automatic word_end(input logic hold);
    @(negedge clk_sys);
    button_active <= hold;
    code_word_done <= 1'b1;
    @(negedge clk_sys);
    code_word_done <= 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : word_end
  task automatic hop_frame(input logic [1:0] flags, input logic [15:0] hop);
    tx(4'h5);
    chk("plain", {4'h5, flags, 10'h2a5, hop}, plain_data);
    word_end(1'b0);
  endtask : hop_frame
  initial
  begin
    reset_n = 1'b0;
    tx_start = 1'b0;
    start = 1'b0;
    image = '0;
    button_bits = 4'h0;
    button_active = 1'b0;
    repeat_word = 1'b1;
    code_word_done = 1'b0;
    below_trip_low = 1'b0;
    below_trip_high = 1'b1;
    repeat (5) @(negedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    load_image(img(16'hfffe, 16'h1ea5, SER));
    chk("key", KEY, cipher_key);
    hop_frame(2'h3, 16'hfffe);
    chk("check_value", 64'h2a5, 64'(plain_data.check_value));
    chk("fixed", {1'b1, 1'b1, 4'h5, SER[27:0]}, fixed_data);
    hop_frame(2'h3, 16'hffff);
    hop_frame(2'h2, 16'h0000);
    load_image(img(16'hffff, 16'h0aa5, SER));
    hop_frame(2'h2, 16'hffff);
    hop_frame(2'h0, 16'h0000);
    hop_frame(2'h0, 16'h0001);
    chk("low_battery", 64'h0, {63'h0, low_battery});
    below_trip_low <= 1'b1;
    @(negedge clk_sys);
    chk("low_battery", 64'h1, {63'h0, low_battery});
    for (int r = 0; r < 4; r++)
    begin
      load_image(img(16'h0000, {1'b0, 2'(r), 13'h0000}, {1'b0, SER[30:0]}));
      button_active <= 1'b1;
      tx(4'h1);
      while (pulse_tick !== 1'b1 && n < 40)
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      n = 0;
      do
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end while (pulse_tick !== 1'b1 && n < 40);
      chk("tick_gap", 64'(GAP[r]), 64'(n));
      chk("send_first", 64'h1, {63'h0, word_send});
      word_end(1'b1);
      chk("send_second", 64'(r == 0), {63'h0, word_send});
      word_end(1'b0);
    end
    load_image(img(16'h0000, 16'h0000, SER));
    button_active <= 1'b1;
    tx(4'h2);
    chk("send_before", 64'h1, {63'h0, word_send});
    repeat (SH + 3) @(negedge clk_sys);
    chk("timed_out", 64'h1, {63'h0, timed_out});
    chk("send_muted", 64'h0, {63'h0, word_send});
    tx_start <= 1'b1;
    @(negedge clk_sys);
    tx_start <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("busy", 64'h0, {63'h0, busy});
    word_end(1'b0);
    chk("timed_out", 64'h0, {63'h0, timed_out});
    load_image(img(16'h0000, 16'h0000, {1'b0, SER[30:0]}));
    button_active <= 1'b1;
    repeat (SH + 5) @(negedge clk_sys);
    chk("timed_out", 64'h0, {63'h0, timed_out});
    give_verdict();
  end
  // Whole run is near 400 cycles; a hundred times that means a hang
  initial
  begin
    #320000;
    failures++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// *** verilog/hcnvm_divider.sv ***
// Restartable cycle divider giving one-cycle enable pulses
`timescale 1ns/1ps
`default_nettype none
module hcnvm_divider #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [W-1:0] period,
  output logic tick
);
  logic [W-1:0] count_q;
  logic at_end;

  assign at_end = (count_q >= period - W'(1));
  assign tick = run & at_end;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= '0;
    end
    else if (!run || at_end)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_q + W'(1);
    end
  end
endmodule : hcnvm_divider
`default_nettype wire

// *** verilog/hcnvm_pkg.sv ***
// Constants and carrier types of the encoder parameter store
package hcnvm_pkg;

  // ==================================================
  // Array geometry and word indices
  localparam int WORD_W = 16;
  localparam int WORD_COUNT = 12;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] IDX_KEY0 = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_KEY1 = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_KEY2 = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_KEY3 = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_HOP_COUNTER = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_RESERVED_A = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_UNIT_ID_LOW = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_UNIT_ID_HIGH = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_UNUSED_A = 4'h8;
  localparam logic [ADDR_W-1:0] IDX_UNUSED_B = 4'h9;
  localparam logic [ADDR_W-1:0] IDX_RESERVED_B = 4'ha;
  localparam logic [ADDR_W-1:0] IDX_OPTION_WORD = 4'hb;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  // ==================================================
  // Field positions
  localparam int CHECK_LSB = 0;
  localparam int CHECK_W = 10;
  localparam int FIRST_WRAP_BIT = 10;
  localparam int SECOND_WRAP_BIT = 11;
  localparam int BATT_SEL_BIT = 12;
  localparam int RATE_LO_BIT = 13;
  localparam int RATE_HI_BIT = 14;
  localparam int OPTION_RSVD_BIT = 15;
  localparam int AUTO_OFF_BIT = 15;
  localparam int SERIAL_SENT_W = 28;
  localparam logic [WORD_W-1:0] HOP_MAX = 16'hffff;
  localparam logic [WORD_W-1:0] HOP_ONE = 16'h0001;

  // ==================================================
  // Rate codes and timing
  localparam logic [1:0] RATE_400_ALL = 2'h0;
  localparam logic [1:0] RATE_200_HALF = 2'h1;
  localparam logic [1:0] RATE_100_HALF = 2'h2;
  localparam logic [1:0] RATE_100_QUART = 2'h3;
  localparam int CLK_PERIOD_NS = 8;
  localparam longint CLK_HZ = 125_000_000;
  localparam int ELEM_400_NS = 400_000;
  localparam int ELEM_200_NS = 200_000;
  localparam int ELEM_100_NS = 100_000;
  localparam int ELEM_400_CYC = ELEM_400_NS / CLK_PERIOD_NS;
  localparam int ELEM_200_CYC = ELEM_200_NS / CLK_PERIOD_NS;
  localparam int ELEM_100_CYC = ELEM_100_NS / CLK_PERIOD_NS;
  localparam int ELEM_W = 16;
  localparam longint SHUTOFF_S = 25;
  localparam longint SHUTOFF_CYC = SHUTOFF_S * CLK_HZ;
  localparam int SHUTOFF_W = 32;

  // ==================================================
  // Carriers
  typedef struct packed {
    logic [3:0] button;
    logic [1:0] wrap_flags;
    logic [CHECK_W-1:0] check_value;
    logic [WORD_W-1:0] hop_count;
  } hcnvm_plain_type;

  typedef struct packed {
    logic repeat_bit;
    logic low_battery;
    logic [3:0] button;
    logic [SERIAL_SENT_W-1:0] serial;
  } hcnvm_fixed_type;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } hcnvm_write_type;

endpackage : hcnvm_pkg

// *** verilog/hcnvm_store.sv ***
// Parameter store, frame forming, counter update and shutoff timer
`timescale 1ns/1ps
`default_nettype none
module hcnvm_store
  import hcnvm_pkg::*;
#(
  parameter logic [ELEM_W-1:0] ELEM_400 = ELEM_W'(hcnvm_pkg::ELEM_400_CYC),
  parameter logic [ELEM_W-1:0] ELEM_200 = ELEM_W'(hcnvm_pkg::ELEM_200_CYC),
  parameter logic [ELEM_W-1:0] ELEM_100 = ELEM_W'(hcnvm_pkg::ELEM_100_CYC),
  parameter logic [SHUTOFF_W-1:0] SHUTOFF = SHUTOFF_W'(hcnvm_pkg::SHUTOFF_CYC)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic prog_mode,
  input wire hcnvm_pkg::hcnvm_write_type prog_write,
  input wire logic tx_start,
  input wire logic [3:0] button_bits,
  input wire logic button_active,
  input wire logic repeat_word,
  input wire logic code_word_done,
  input wire logic below_trip_low,
  input wire logic below_trip_high,
  output logic [63:0] cipher_key,
  output hcnvm_pkg::hcnvm_plain_type plain_data,
  output hcnvm_pkg::hcnvm_fixed_type fixed_data,
  output logic frame_ready,
  output logic busy,
  output logic pulse_tick,
  output logic word_send,
  output logic timed_out,
  output logic low_battery
);
  import hcnvm_pkg::*;

  // ==================================================
  // Sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_STORE = 3'b100
  } hcnvm_state_type;

  hcnvm_state_type state_q;
  logic [WORD_W-1:0] mem_q [WORD_COUNT];
  logic [WORD_W-1:0] option_word;
  logic [WORD_W-1:0] hop_next;
  logic [1:0] flags_next;
  logic [1:0] rate_sel;
  logic check_fire;
  logic auto_off_en;
  logic [SHUTOFF_W-1:0] idle_count_q;
  logic timed_out_q;
  logic shutoff_due;
  logic slot_send;
  logic frame_ready_q;
  logic frame_active_q;
  logic [1:0] word_index_q;
  logic [ELEM_W-1:0] elem_period;
  hcnvm_plain_type plain_q;
  hcnvm_fixed_type fixed_q;

  assign option_word = mem_q[IDX_OPTION_WORD];
  assign rate_sel = {option_word[RATE_HI_BIT], option_word[RATE_LO_BIT]};
  assign auto_off_en = mem_q[IDX_UNIT_ID_HIGH][AUTO_OFF_BIT];
  assign check_fire = tx_start && !prog_mode && !timed_out_q;
  assign busy = (state_q != ST_IDLE);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (check_fire)
          begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          state_q <= ST_STORE;
        end
        ST_STORE:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==================================================
  // Storage array
  // Modelled blank at reset; programmer writes win over a store-back
  always_comb
  begin
    hop_next = mem_q[IDX_HOP_COUNTER] + HOP_ONE;
    flags_next = {option_word[SECOND_WRAP_BIT], option_word[FIRST_WRAP_BIT]};
    if (mem_q[IDX_HOP_COUNTER] == HOP_MAX)
    begin
      // Flags are only ever cleared here, never set
      if (flags_next[0])
      begin
        flags_next[0] = 1'b0;
      end
      else
      begin
        flags_next[1] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < WORD_COUNT; i++)
      begin
        mem_q[i] <= WORD_RESET;
      end
    end
    else if (prog_mode && prog_write.we)
    begin
      // Words past the array are dropped
      if (prog_write.addr == IDX_OPTION_WORD)
      begin
        mem_q[IDX_OPTION_WORD] <= {1'b0, prog_write.data[OPTION_RSVD_BIT-1:0]};
      end
      else if (prog_write.addr < ADDR_W'(WORD_COUNT))
      begin
        mem_q[prog_write.addr] <= prog_write.data;
      end
    end
    else if (state_q == ST_STORE)
    begin
      mem_q[IDX_HOP_COUNTER] <= hop_next;
      mem_q[IDX_OPTION_WORD][FIRST_WRAP_BIT] <= flags_next[0];
      mem_q[IDX_OPTION_WORD][SECOND_WRAP_BIT] <= flags_next[1];
    end
  end

  assign cipher_key = {mem_q[IDX_KEY3], mem_q[IDX_KEY2], mem_q[IDX_KEY1], mem_q[IDX_KEY0]};

  // ==================================================
  // Frame forming
  assign low_battery = option_word[BATT_SEL_BIT] ? below_trip_high : below_trip_low;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      plain_q <= '0;
      fixed_q <= '0;
      frame_ready_q <= 1'b0;
    end
    else
    begin
      frame_ready_q <= (state_q == ST_LOAD);
      if (state_q == ST_LOAD)
      begin
        plain_q.button <= button_bits;
        plain_q.wrap_flags <= {option_word[SECOND_WRAP_BIT], option_word[FIRST_WRAP_BIT]};
        plain_q.check_value <= option_word[CHECK_LSB +: CHECK_W];
        plain_q.hop_count <= mem_q[IDX_HOP_COUNTER];
        fixed_q.repeat_bit <= repeat_word;
        fixed_q.low_battery <= low_battery;
        fixed_q.button <= button_bits;
        // Bits 28-31 stay private; bit 31 is the shutoff enable
        fixed_q.serial <= {mem_q[IDX_UNIT_ID_HIGH][SERIAL_SENT_W-WORD_W-1:0],
                           mem_q[IDX_UNIT_ID_LOW]};
      end
    end
  end

  assign plain_data = plain_q;
  assign fixed_data = fixed_q;
  assign frame_ready = frame_ready_q;

  // ==================================================
  // Pulse element and blanking
  always_comb
  begin
    unique case (rate_sel)
      RATE_400_ALL: elem_period = ELEM_400;
      RATE_200_HALF: elem_period = ELEM_200;
      RATE_100_HALF: elem_period = ELEM_100;
      RATE_100_QUART: elem_period = ELEM_100;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_active_q <= 1'b0;
      word_index_q <= 2'h0;
    end
    else if (check_fire && state_q == ST_IDLE)
    begin
      frame_active_q <= 1'b1;
      word_index_q <= 2'h0;
    end
    else if (code_word_done && frame_active_q)
    begin
      word_index_q <= word_index_q + 2'h1;
      if (!button_active || timed_out_q)
      begin
        frame_active_q <= 1'b0;
      end
    end
  end

  hcnvm_divider #(
    .W(ELEM_W)
  ) u_elem_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(frame_active_q),
    .period(elem_period),
    .tick(pulse_tick)
  );

  // Blanked words still take their slot in time; only the carrier is held off
  always_comb
  begin
    unique case (rate_sel)
      RATE_400_ALL: slot_send = 1'b1;
      RATE_200_HALF: slot_send = !word_index_q[0];
      RATE_100_HALF: slot_send = !word_index_q[0];
      RATE_100_QUART: slot_send = (word_index_q == 2'h0);
    endcase
  end

  // Carrier goes quiet the moment the shutoff fires, not at the word's end
  assign word_send = frame_active_q && slot_send && !timed_out_q;

  // ==================================================
  // Stuck-button shutoff
  // Fixed period, no field selects it
  assign shutoff_due = (idle_count_q >= SHUTOFF - SHUTOFF_W'(1));

  // Count freezes at expiry so it can never roll over and drop the flag
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idle_count_q <= '0;
    end
    else if (!button_active || !auto_off_en)
    begin
      idle_count_q <= '0;
    end
    else if (!shutoff_due)
    begin
      idle_count_q <= idle_count_q + SHUTOFF_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timed_out_q <= 1'b0;
    end
    else if (!button_active || !auto_off_en)
    begin
      timed_out_q <= 1'b0;
    end
    else if (shutoff_due)
    begin
      timed_out_q <= 1'b1;
    end
  end

  assign timed_out = timed_out_q;

endmodule : hcnvm_store
`default_nettype wire
